//--- hdl/tws_pkg.sv
// Constants and types for the three-wire control slave
// Behaviour
// - Six-bit addresses; zero reserved, 63 usable
// - Byte bits 1:0 type, 7:2 address
// - Address 7:5 system, 4:2 device
// - Only the matching slave joins the data
// - Types: write, read, control, status read
// - Direction fixed until next address phase
// - Data: mode high, eight pulses, LSB first
// - Byte units; 16-bit as two bytes
// - Bit counting slave also handles pauses
// - Zero address, type 00: everyone silent
// - Own valid address ends interface reset
// - Fixed slave resets on zero address
// - Programmable slave resets on types 00 and 11
// - Type 01 declares address after code
// - Code bit 0 flags more; all must match
// - Type 10 with code invalidates address
// - Type 11 on zero address resets
package tws_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 6;
    localparam int TYPE_W = 2;
    localparam int CNT_W = 4;
    localparam int SYNC_N = 3;
    localparam logic [CNT_W-1:0] BITS_PER_UNIT = 4'h8;
    localparam logic [ADDR_W-1:0] SPECIAL_ADDR = 6'h00;
    // Field positions in the address byte and the code bytes
    localparam int TT_LSB = 0;
    localparam int TT_MSB = 1;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;
    localparam int SYS_LSB = 5;
    localparam int DEV_MSB = 4;
    localparam int ID_MORE_BIT = 0;
    // Transfer type encodings
    localparam logic [TYPE_W-1:0] TT_DATA_WR = 2'h0;
    localparam logic [TYPE_W-1:0] TT_DATA_RD = 2'h1;
    localparam logic [TYPE_W-1:0] TT_CTRL_WR = 2'h2;
    localparam logic [TYPE_W-1:0] TT_STAT_RD = 2'h3;
    localparam logic [TYPE_W-1:0] TT_DECLARE = 2'h1;
    localparam logic [TYPE_W-1:0] TT_INVALIDATE = 2'h2;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOW = 2'b01,
        PH_ADDR = 2'b10,
        PH_DATA = 2'b11
    } tws_phase_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_WR = 3'b001,
        OP_RD = 3'b010,
        OP_DECL = 3'b011,
        OP_INVAL = 3'b100,
        OP_SKIP = 3'b101
    } tws_op_t;
endpackage

//--- hdl/tws_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module tws_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    typedef struct packed {
        logic o_valid;
        logic [WIDTH-1:0] o_data;
        logic sp_valid;
        logic [WIDTH-1:0] sp_data;
    } tws_buf_t;

    tws_buf_t s;
    tws_buf_t next_s;
    logic push;
    logic pop;

    // Spare entry absorbs a word while the drain side stalls
    always_comb begin
        next_s = s;
        push = in_valid & ~s.sp_valid;
        pop = s.o_valid & out_ready;
        if (pop || !s.o_valid) begin
            if (s.sp_valid) begin
                next_s.o_valid = 1'b1;
                next_s.o_data = s.sp_data;
                next_s.sp_valid = 1'b0;
            end else begin
                next_s.o_valid = push;
                next_s.o_data = in_data;
            end
        end else if (push) begin
            next_s.sp_valid = 1'b1;
            next_s.sp_data = in_data;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready = ~s.sp_valid; // Full only when both entries hold
    assign out_valid = s.o_valid;
    assign out_data = s.o_data;
endmodule

//--- hdl/tws_slave.sv
// Three-wire control bus slave: phase decoding, data and addressing
`timescale 1ns/100ps
module tws_slave
    import tws_pkg::*;
#(
    parameter bit PROGRAMMABLE = 1'b1,
    // Arbitrary address, used when not programmable
    parameter logic [ADDR_W-1:0] FIXED_ADDR = 6'h39,
    parameter int ID_BYTES = 2,
    // Arbitrary identification code, first byte in the low bits
    parameter logic [8*ID_BYTES-1:0] ID_CODE = 16'h3ac5
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bus lines
    input wire logic phase_select_line,
    input wire logic serial_bit_clock,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Received write bytes
    output logic rx_valid,
    output logic [BYTE_W-1:0] rx_data,
    input wire logic rx_ready,
    // Bytes to send on reads
    input wire logic [BYTE_W-1:0] tx_data,
    output logic tx_take,
    // Status
    output logic selected,
    output logic [TYPE_W-1:0] transfer_type_field,
    output logic [ADDR_W-1:0] device_address_field,
    output logic address_valid,
    output logic overrun
);
    localparam int ID_IDX_W = $clog2(ID_BYTES + 1);

    typedef struct packed {
        logic [SYNC_N-1:0] mode_sync;
        logic [SYNC_N-1:0] clk_sync;
        logic [SYNC_N-1:0] data_sync;
        logic mode_f;
        logic clk_f;
        logic data_f;
        tws_phase_t phase;
        tws_op_t op;
        logic [CNT_W-1:0] bit_cnt;
        logic [BYTE_W-1:0] shift;
        logic [BYTE_W-1:0] tx_shift;
        logic [ID_IDX_W-1:0] id_idx;
        logic id_done;
        logic [ADDR_W-1:0] own_addr;
        logic addr_valid;
        logic [TYPE_W-1:0] ttype;
        logic selected;
        logic [BYTE_W-1:0] hold;
        logic hold_valid;
        logic overrun;
        logic tx_take;
        logic sd_out;
        logic sd_oe;
    } tws_state_t;

    tws_state_t s;
    tws_state_t next_s;
    logic buf_ready;
    logic mode_n;
    logic clk_n;
    logic data_n;
    logic clk_rise;
    logic clk_fall;
    logic mode_rise;
    logic mode_fall;
    logic [BYTE_W-1:0] byte_in;
    logic [ADDR_W-1:0] a_addr;
    logic [TYPE_W-1:0] a_type;
    logic [BYTE_W-1:0] id_byte;

    // Draining side may stall; the hold register waits for room
    tws_buffer #(.WIDTH(BYTE_W)) u_buffer (
        .clock(clock),
        .reset(reset),
        .in_valid(s.hold_valid),
        .in_data(s.hold),
        .in_ready(buf_ready),
        .out_valid(rx_valid),
        .out_data(rx_data),
        .out_ready(rx_ready)
    );

    // Filtered line levels; a change counts once stages two and three agree
    always_comb begin
        mode_n = (s.mode_sync[1] == s.mode_sync[2]) ? s.mode_sync[2] :
            s.mode_f;
        clk_n = (s.clk_sync[1] == s.clk_sync[2]) ? s.clk_sync[2] : s.clk_f;
        data_n = (s.data_sync[1] == s.data_sync[2]) ? s.data_sync[2] :
            s.data_f;
        clk_rise = clk_n & ~s.clk_f;
        clk_fall = ~clk_n & s.clk_f;
        mode_rise = mode_n & ~s.mode_f;
        mode_fall = ~mode_n & s.mode_f;
        byte_in = {data_n, s.shift[BYTE_W-1:1]}; // LSB first
        a_addr = s.shift[ADDR_MSB:ADDR_LSB];
        a_type = s.shift[TT_MSB:TT_LSB];
        id_byte = (s.id_idx < ID_IDX_W'(ID_BYTES)) ?
            ID_CODE[8*s.id_idx +: 8] : ~byte_in;
    end

    // Phase tracking, address decode and data handling
    always_comb begin
        next_s = s;
        next_s.mode_sync = {s.mode_sync[1:0], phase_select_line};
        next_s.clk_sync = {s.clk_sync[1:0], serial_bit_clock};
        next_s.data_sync = {s.data_sync[1:0], serial_data_line_in};
        next_s.mode_f = mode_n;
        next_s.clk_f = clk_n;
        next_s.data_f = data_n;
        next_s.tx_take = 1'b0;
        if (s.hold_valid && buf_ready) begin
            next_s.hold_valid = 1'b0;
        end
        unique case (s.phase)
            PH_IDLE, PH_DATA: begin
                if (mode_fall) begin
                    // Pause or a new address; release data at once
                    next_s.phase = PH_LOW;
                    next_s.sd_oe = 1'b0;
                end else if (s.phase == PH_DATA && clk_rise) begin
                    next_s.shift = byte_in;
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    next_s.sd_out = s.tx_shift[1];
                    next_s.tx_shift = {1'b0, s.tx_shift[BYTE_W-1:1]};
                    if (s.bit_cnt + 4'h1 == BITS_PER_UNIT) begin
                        // Unit done; bit counter lets mode stay high
                        next_s.bit_cnt = '0;
                        unique case (s.op)
                            OP_WR: begin
                                // Words of 16 bits pass as bytes in order
                                if (next_s.hold_valid) begin
                                    next_s.overrun = 1'b1;
                                end else begin
                                    next_s.hold = byte_in;
                                    next_s.hold_valid = 1'b1;
                                end
                            end
                            OP_RD: begin
                                next_s.tx_shift = tx_data;
                                next_s.sd_out = tx_data[0];
                                next_s.tx_take = 1'b1;
                            end
                            OP_DECL, OP_INVAL: begin
                                if (s.id_done) begin
                                    // Address byte; type bits ignored
                                    next_s.own_addr =
                                        byte_in[ADDR_MSB:ADDR_LSB];
                                    next_s.addr_valid = 1'b1;
                                    next_s.op = OP_SKIP;
                                end else if (byte_in != id_byte) begin
                                    next_s.op = OP_SKIP;
                                end else if (!byte_in[ID_MORE_BIT]) begin
                                    if (s.op == OP_INVAL) begin
                                        next_s.addr_valid = 1'b0;
                                        next_s.op = OP_SKIP;
                                    end else begin
                                        next_s.id_done = 1'b1;
                                    end
                                end else begin
                                    next_s.id_idx = s.id_idx + 1'b1;
                                end
                            end
                            OP_NONE, OP_SKIP: begin
                                next_s.op = s.op;
                            end
                            default: begin
                                next_s.op = OP_NONE;
                            end
                        endcase
                    end
                end
            end
            PH_LOW: begin
                if (clk_fall) begin
                    // Clock falls while mode is low: an address phase
                    next_s.phase = PH_ADDR;
                    next_s.bit_cnt = '0;
                end else if (mode_rise) begin
                    // Pause over; next unit starts from bit zero
                    next_s.phase = (s.op == OP_NONE) ? PH_IDLE : PH_DATA;
                    next_s.bit_cnt = '0;
                    next_s.sd_oe = (s.op == OP_RD);
                    next_s.sd_out = s.tx_shift[0];
                end
            end
            PH_ADDR: begin
                if (clk_rise) begin
                    next_s.shift = byte_in;
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                end else if (mode_rise) begin
                    next_s.phase = PH_DATA;
                    next_s.op = OP_NONE;
                    next_s.selected = 1'b0;
                    next_s.id_idx = '0;
                    next_s.id_done = 1'b0;
                    // First unit counts from zero even without a pause
                    next_s.bit_cnt = '0;
                    if (s.bit_cnt != BITS_PER_UNIT) begin
                        next_s.phase = PH_IDLE; // Short address ignored
                    end else if (a_addr == SPECIAL_ADDR) begin
                        // Fixed slave: interface reset on any type
                        if (PROGRAMMABLE && a_type == TT_DECLARE) begin
                            next_s.op = OP_DECL;
                        end else if (PROGRAMMABLE &&
                                a_type == TT_INVALIDATE) begin
                            next_s.op = OP_INVAL;
                        end else begin
                            next_s.op = OP_NONE;
                        end
                    end else if (s.addr_valid && a_addr == s.own_addr) begin
                        // Whole six bits compared: system and device parts
                        next_s.selected = 1'b1;
                        next_s.ttype = a_type;
                        next_s.overrun = 1'b0;
                        // Odd types read; direction held for the phase
                        next_s.op = a_type[TT_LSB] ? OP_RD : OP_WR;
                    end
                    if (next_s.op == OP_RD) begin
                        next_s.sd_oe = 1'b1;
                        next_s.tx_shift = tx_data;
                        next_s.sd_out = tx_data[0];
                        next_s.tx_take = 1'b1;
                    end
                    if (next_s.op == OP_NONE) begin
                        next_s.phase = PH_IDLE;
                    end
                end
            end
        endcase
    end

    // All state in one register; address valid only after reset if fixed
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.mode_sync <= 3'h7;
            s.clk_sync <= 3'h7;
            s.mode_f <= 1'b1;
            s.clk_f <= 1'b1;
            s.own_addr <= FIXED_ADDR;
            s.addr_valid <= ~PROGRAMMABLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign serial_data_line_out = s.sd_out;
    assign serial_data_line_oe = s.sd_oe;
    assign tx_take = s.tx_take;
    assign selected = s.selected;
    assign transfer_type_field = s.ttype;
    assign device_address_field = s.own_addr;
    assign address_valid = s.addr_valid;
    assign overrun = s.overrun;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence mode_low_held;
        !phase_select_line [*5];
    endsequence
    sequence addr_done;
        s.phase == PH_ADDR && !clk_rise && mode_rise &&
            s.bit_cnt == BITS_PER_UNIT;
    endsequence
    sequence pause_over;
        s.phase == PH_LOW && !clk_fall && mode_rise;
    endsequence

    a_sync_mode_level:
    assert property (mode_low_held |=> !s.mode_f)
        else $error("mode level not taken after sync");
    a_drive_only_read:
    assert property (s.sd_oe |-> s.op == OP_RD && s.phase == PH_DATA)
        else $error("data line driven outside a read phase");
    a_special_reset:
    assert property (addr_done ##0 (a_addr == SPECIAL_ADDR &&
            (a_type == TT_DATA_WR || a_type == TT_STAT_RD))
            |=> s.op == OP_NONE && !s.selected && !s.sd_oe)
        else $error("special address did not reset interface");
    a_match_select:
    assert property (addr_done ##0 (a_addr != SPECIAL_ADDR &&
            a_addr == s.own_addr && s.addr_valid)
            |=> s.selected && s.phase == PH_DATA)
        else $error("matching address did not select slave");
    a_other_ignored:
    assert property (addr_done ##0 (a_addr != s.own_addr ||
            !s.addr_valid) |=> !s.selected ##1 !s.sd_oe)
        else $error("foreign address selected slave");
    a_read_type:
    assert property (s.selected && s.op == OP_RD |-> s.ttype[TT_LSB])
        else $error("read op with a write type");
    a_pause_keeps:
    assert property (pause_over ##0 (s.op != OP_NONE)
            |=> s.phase == PH_DATA && s.bit_cnt == '0)
        else $error("pause did not resume data phase");
    a_direction_held:
    assert property (s.phase == PH_DATA && !mode_fall && s.op == OP_RD
            |=> s.op == OP_RD || s.phase != PH_DATA)
        else $error("direction changed inside data phase");
    a_write_to_buffer:
    assert property (s.phase == PH_DATA && s.op == OP_WR && clk_rise &&
            s.bit_cnt == 4'h7 && !next_s.overrun
            |=> s.hold_valid && s.hold == $past(byte_in))
        else $error("written byte not held LSB first");
    a_declare_addr:
    assert property (s.phase == PH_DATA && s.op == OP_DECL && s.id_done &&
            clk_rise && s.bit_cnt == 4'h7
            |=> s.addr_valid && s.own_addr == $past(byte_in[ADDR_MSB:ADDR_LSB]))
        else $error("declared address not stored");
endmodule

//--- bench/tws_master.sv
// Bus master model: drives mode and bit clock, shares the data line
`timescale 1ns/100ps
module tws_master (
    // System clock used to pace the link
    input wire logic clock,
    // Lines driven by the master
    output logic phase_select_line,
    output logic serial_bit_clock,
    output logic data_out,
    output logic data_drive,
    // Data line level as seen on the wire
    input wire logic data_in
);
    // Idle lines high at time zero; mode and clock always driven
    initial begin
        phase_select_line = 1'b1;
        serial_bit_clock = 1'b1;
        data_out = 1'b1;
        data_drive = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One bit: clock low with the data held, sample just before the rise
    task automatic one_bit(input logic v, output logic s);
        wait_cyc(4);
        serial_bit_clock <= 1'b0;
        data_out <= v; // Stable through the low phase
        wait_cyc(4);
        s = data_in;
        serial_bit_clock <= 1'b1;
    endtask

    // Eight bits, least significant first
    task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
        logic s;
        for (int i = 0; i < 8; i++) begin
            one_bit(b[i], s);
            r[i] = s;
        end
        // Hold the last bit past the rise, then let go of the line
        wait_cyc(4);
        data_drive <= 1'b0;
        wait_cyc(4);
    endtask

    // Address phase: mode low, eight pulses, mode high
    task automatic frame_addr(input logic [7:0] b);
        logic [7:0] r;
        phase_select_line <= 1'b0;
        wait_cyc(8);
        data_drive <= 1'b1;
        shift_byte(b, r);
        phase_select_line <= 1'b1;
        wait_cyc(8);
    endtask

    // Write unit: master drives data only while it sends
    task automatic wr_byte(input logic [7:0] b);
        logic [7:0] r;
        data_drive <= 1'b1;
        shift_byte(b, r);
    endtask

    // Read unit: line released, slave answers
    task automatic rd_byte(output logic [7:0] r);
        shift_byte(8'hff, r);
    endtask

    // Pause between units: mode low, clock kept high
    task automatic pause;
        phase_select_line <= 1'b0;
        wait_cyc(8);
        phase_select_line <= 1'b1;
        wait_cyc(8);
    endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the three-wire control slave
`timescale 1ns/100ps
module testbench;
    import tws_pkg::*;
    logic clock;
    logic reset;
    logic mode;
    logic bclk;
    logic m_dout;
    logic m_drive;
    logic idle_pat = 1'b0;
    logic sdl;
    logic out;
    logic oe;
    logic rx_valid;
    logic rx_ready;
    logic tx_take;
    logic selected;
    logic address_valid;
    logic overrun;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic [1:0] ttype;
    logic [5:0] dev_addr;
    int n_errors = 0;
    int compares = 0;
    int n_take = 0;

    // Released line shows a toggling pattern, never the last value
    assign sdl = oe ? out : (m_drive ? m_dout : idle_pat);

    tws_master u_m (
        .clock(clock),
        .phase_select_line(mode),
        .serial_bit_clock(bclk),
        .data_out(m_dout),
        .data_drive(m_drive),
        .data_in(sdl)
    );

    tws_slave u_dut (
        .clock(clock),
        .reset(reset),
        .phase_select_line(mode),
        .serial_bit_clock(bclk),
        .serial_data_line_in(sdl),
        .serial_data_line_out(out),
        .serial_data_line_oe(oe),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_ready(rx_ready),
        .tx_data(tx_data),
        .tx_take(tx_take),
        .selected(selected),
        .transfer_type_field(ttype),
        .device_address_field(dev_addr),
        .address_valid(address_valid),
        .overrun(overrun)
    );

    // System clock, 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) idle_pat <= ~idle_pat;

    // Count loads of the read shifter
    always @(posedge clock) begin
        if (tx_take === 1'b1) begin
            n_take <= n_take + 1;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Programmable slave starts without an address
    task automatic t_reset_state;
        chk({7'h0, address_valid}, 8'h00, "addr valid");
        chk({2'h0, dev_addr}, 8'h39, "fixed addr");
        chk({7'h0, oe}, 8'h00, "oe idle");
    endtask

    // Declaration with a code, first a wrong one, then the right one
    task automatic t_declare;
        u_m.frame_addr(8'h01);
        u_m.wr_byte(8'hc5);
        u_m.wr_byte(8'h3b); // Last byte differs
        u_m.wr_byte(8'hf0);
        chk({7'h0, address_valid}, 8'h00, "bad code");
        u_m.frame_addr(8'h01);
        u_m.wr_byte(8'hc5);
        u_m.pause();
        u_m.wr_byte(8'h3a);
        u_m.wr_byte(8'hf3); // Type bits ignored; 111100
        chk({7'h0, address_valid}, 8'h01, "declared");
        chk({2'h0, dev_addr}, 8'h3c, "new addr");
    endtask

    // Each type selects; reported with the right encoding
    task automatic t_types;
        for (int t = 0; t < 4; t++) begin
            u_m.frame_addr({6'h3c, t[1:0]});
            chk({7'h0, selected}, 8'h01, "selected");
            chk({6'h0, ttype}, {6'h0, t[1:0]}, "type");
        end
    endtask

    // Writes LSB first, back to back and with a pause, receiver stalls
    task automatic t_write;
        rx_ready <= 1'b0;
        u_m.frame_addr(8'hf0);
        u_m.wr_byte(8'h12); // 16-bit unit, high byte first
        u_m.wr_byte(8'h34); // No pause between units
        u_m.pause();
        chk({7'h0, rx_valid}, 8'h01, "rx valid");
        chk(rx_data, 8'h12, "rx first");
        chk({7'h0, overrun}, 8'h00, "no overrun");
        u_m.wr_byte(8'h56); // Waits in the hold register
        u_m.wr_byte(8'h78); // No room left: dropped
        chk({7'h0, overrun}, 8'h01, "overrun");
        // One pop, then look while the next head stands
        rx_ready <= 1'b1;
        @(posedge clock);
        rx_ready <= 1'b0;
        #1;
        chk({7'h0, rx_valid}, 8'h01, "rx next");
        chk(rx_data, 8'h34, "rx second");
        @(posedge clock);
        rx_ready <= 1'b1;
        @(posedge clock);
        #1;
        chk(rx_data, 8'h56, "rx third");
        @(posedge clock);
        #1;
        chk({7'h0, rx_valid}, 8'h00, "drained");
        @(posedge clock);
        rx_ready <= 1'b0;
    endtask

    // Read: slave drives the line, direction stays read
    task automatic t_read;
        logic [7:0] r;
        int takes;
        takes = n_take;
        tx_data <= 8'h96;
        u_m.frame_addr(8'hf1);
        chk({7'h0, oe}, 8'h01, "oe on");
        chk({7'h0, overrun}, 8'h00, "overrun cleared");
        tx_data <= 8'h5a; // Loaded at the end of the first unit
        u_m.rd_byte(r);
        chk(r, 8'h96, "read byte");
        u_m.rd_byte(r);
        chk(r, 8'h5a, "read again");
        chk(8'(n_take - takes), 8'h03, "tx takes");
        u_m.frame_addr(8'h54); // Another device
        chk({7'h0, oe}, 8'h00, "oe off");
        chk({7'h0, selected}, 8'h00, "not ours");
        u_m.wr_byte(8'h77);
        chk({7'h0, rx_valid}, 8'h00, "ignored");
    endtask

    // Zero address with type 00 and 11 silences; own address resumes
    task automatic t_iface_reset;
        logic [7:0] r;
        u_m.frame_addr(8'h00);
        u_m.rd_byte(r);
        chk({6'h0, selected, oe}, 8'h00, "reset 00");
        u_m.frame_addr(8'hf0);
        chk({7'h0, selected}, 8'h01, "resume");
        u_m.frame_addr(8'h03);
        chk({6'h0, selected, oe}, 8'h00, "reset 11");
        chk({7'h0, address_valid}, 8'h01, "kept addr");
    endtask

    // Invalidation with the code drops the address
    task automatic t_invalidate;
        u_m.frame_addr(8'h02);
        u_m.wr_byte(8'hc5);
        u_m.wr_byte(8'h3a);
        chk({7'h0, address_valid}, 8'h00, "invalid");
        u_m.frame_addr(8'hf0);
        chk({7'h0, selected}, 8'h00, "silent");
    endtask

    // Main sequence; all inputs valued at time zero
    initial begin
        reset = 1'b1;
        rx_ready = 1'b0;
        tx_data = 8'h00;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        repeat (8) @(posedge clock);
        t_reset_state();
        t_declare();
        t_types();
        t_write();
        t_read();
        t_iface_reset();
        t_invalidate();
        give_verdict();
    end

    // Watchdog, well above the expected run of some 2400 cycles
    initial begin
        #400000;
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
